/* File: hdl/rca_counter_alarm.sv */
// Real-time clock core: second counter, calendar, alarm and pulse output.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
module rca_counter_alarm
  import rca_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         lsclk,
  input  wire rca_bus_req_s bus_req,
  output logic [7:0]        rdata,
  output rca_event_s        events
);

  typedef struct packed {
    logic [2:0]       ls_sync;
    logic             ls_level;
    logic [DIV_W-1:0] div;
    logic [7:0]       sec;
    logic [7:0]       min;
    logic [7:0]       hour;
    logic [2:0]       wday;
    logic [7:0]       date;
    logic [7:0]       al_min;
    logic [7:0]       al_hour;
    logic [2:0]       al_wday;
    logic [7:0]       al_date;
    logic             page;
    logic             run_en;
    logic             alarm_en;
    logic             irq_en;
    logic             one_hz_off;
    logic             sixteen_hz_off;
    logic             clear_req;
    logic             pulse;
    logic [7:0]       rdata;
  } rca_state_s;

  // Which event, if any, drives the pin and the interrupt.
  typedef enum logic [1:0] {
    SRC_NONE    = 2'b00,
    SRC_ALARM   = 2'b01,
    SRC_ONE_HZ  = 2'b10,
    SRC_SIXTEEN = 2'b11
  } rca_src_e;

  localparam rca_state_s STATE_RESET = '{
    ls_sync:        3'h0,
    ls_level:       1'b0,
    div:            '0,
    sec:            RST_TIME,
    min:            RST_TIME,
    hour:           RST_TIME,
    wday:           RST_WEEKDAY,
    date:           RST_DATE,
    al_min:         INIT_AL_MINUTE,
    al_hour:        INIT_AL_HOUR,
    al_wday:        INIT_AL_WEEKDAY,
    al_date:        INIT_AL_DATE,
    page:           1'b0,
    run_en:         1'b0,
    alarm_en:       1'b0,
    irq_en:         1'b0,
    one_hz_off:     RST_ONE_HZ_OFF,
    sixteen_hz_off: RST_SIXTEEN_OFF,
    clear_req:      1'b0,
    pulse:          1'b0,
    rdata:          8'h00
  };

  // BCD increment that wraps from last back to first.
  function automatic logic [7:0] rca_bcd_inc(input logic [7:0] v,
                                             input logic [7:0] last,
                                             input logic [7:0] first);
    logic [7:0] r;
    if (v == last) begin
      r = first;
    end else if (v[3:0] == 4'h9) begin
      r = {4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      r = 8'(v + 8'h01);
    end
    return r;
  endfunction : rca_bcd_inc

  // Only three bit patterns select a source; any other mix stays silent
  // rather than merging two pulse trains on one pin.
  function automatic rca_src_e rca_src_decode(input logic alarm_en,
                                              input logic one_hz_off,
                                              input logic sixteen_hz_off);
    rca_src_e s;
    unique case ({alarm_en, one_hz_off, sixteen_hz_off})
      3'b111: begin
        s = SRC_ALARM;
      end
      3'b001: begin
        s = SRC_ONE_HZ;
      end
      3'b010: begin
        s = SRC_SIXTEEN;
      end
      default: begin
        s = SRC_NONE;
      end
    endcase
    return s;
  endfunction : rca_src_decode

  // Page 1 swaps the calendar view for the alarm view at the same index.
  function automatic logic [7:0] rca_page_pick(input logic       page,
                                               input logic [7:0] cal,
                                               input logic [7:0] alarm);
    logic [7:0] r;
    r = page ? alarm : cal;
    return r;
  endfunction : rca_page_pick

  logic [1:0] rst_pipe;
  logic       rst_sync_n;
  rca_state_s cur;
  rca_state_s next_cur;

  // Reset is released through two flops so the release is clean on mclk.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  logic ls_rise;
  logic tick_1hz;
  logic tick_16hz;
  logic cal_step;
  logic sec_wrap;
  logic min_wrap;
  logic hour_wrap;
  logic match;
  logic src_event;
  logic wr_page0;
  logic wr_page1;
  rca_src_e src_sel;

  always_comb begin
    next_cur = cur;

    // The low-speed clock is a pin: three flops, and an edge counts only
    // once the second and third stages agree.
    next_cur.ls_sync = {cur.ls_sync[1:0], lsclk};
    ls_rise = 1'b0;
    if (cur.ls_sync[2] == cur.ls_sync[1]) begin
      next_cur.ls_level = cur.ls_sync[2];
      ls_rise = cur.ls_sync[2] & ~cur.ls_level;
    end

    tick_1hz  = ls_rise && (cur.div == DIV_LAST);
    tick_16hz = ls_rise && ((cur.div & DIV16_MASK) == DIV16_MASK);
    cal_step  = tick_1hz && cur.run_en;
    sec_wrap  = (cur.sec == LAST_SECOND);
    min_wrap  = sec_wrap && (cur.min == LAST_MINUTE);
    hour_wrap = min_wrap && (cur.hour == LAST_HOUR);

    if (ls_rise) begin
      // A pending clear restarts the divider, so the next tick lands one
      // whole second later.
      if (cur.clear_req) begin
        next_cur.div       = '0;
        next_cur.clear_req = 1'b0;
      end else begin
        next_cur.div = DIV_W'(cur.div + 1'b1);
      end
    end

    // Calendar advances only while run-enable is set; the divider above
    // keeps running regardless.
    if (cal_step) begin
      next_cur.sec = rca_bcd_inc(cur.sec, LAST_SECOND, RST_TIME);
      if (sec_wrap) begin
        next_cur.min = rca_bcd_inc(cur.min, LAST_MINUTE, RST_TIME);
      end
      if (min_wrap) begin
        next_cur.hour = rca_bcd_inc(cur.hour, LAST_HOUR, RST_TIME);
      end
      if (hour_wrap) begin
        next_cur.date = rca_bcd_inc(cur.date, LAST_DATE, RST_DATE);
        next_cur.wday = (cur.wday == LAST_WEEKDAY) ? RST_WEEKDAY
                                                   : 3'(cur.wday + 3'h1);
      end
    end

    // The match is taken on the new minute only, once per calendar update,
    // so one alarm time gives exactly one pulse. A freshly written alarm
    // field is only seen at the next low-speed edge.
    match = cal_step && sec_wrap
            && (next_cur.min  == cur.al_min)
            && (next_cur.hour == cur.al_hour)
            && (next_cur.date == cur.al_date)
            && (next_cur.wday == cur.al_wday);

    // Exactly one source reaches the pin; other combinations give none.
    src_sel   = rca_src_decode(cur.alarm_en, cur.one_hz_off,
                               cur.sixteen_hz_off);
    src_event = 1'b0;
    unique case (src_sel)
      SRC_ALARM: begin
        src_event = match;
      end
      SRC_ONE_HZ: begin
        src_event = tick_1hz;
      end
      SRC_SIXTEEN: begin
        src_event = tick_16hz;
      end
      SRC_NONE: begin
        src_event = 1'b0;
      end
    endcase

    // Pin and interrupt share one flop and last one low-speed period.
    if (ls_rise) begin
      next_cur.pulse = src_event && cur.irq_en;
    end

    // Register writes come after the counting so software wins a tie.
    wr_page0 = bus_req.wr && !cur.page;
    wr_page1 = bus_req.wr && cur.page;
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        ADDR_SECOND: begin
          if (wr_page0) begin
            next_cur.sec = bus_req.wdata;
          end
        end
        ADDR_MINUTE: begin
          if (wr_page0) begin
            next_cur.min = bus_req.wdata;
          end else if (wr_page1) begin
            next_cur.al_min = bus_req.wdata;
          end
        end
        ADDR_HOUR: begin
          if (wr_page0) begin
            next_cur.hour = bus_req.wdata;
          end else if (wr_page1) begin
            next_cur.al_hour = bus_req.wdata;
          end
        end
        ADDR_WEEKDAY: begin
          if (wr_page0) begin
            next_cur.wday = bus_req.wdata[2:0];
          end else if (wr_page1) begin
            next_cur.al_wday = bus_req.wdata[2:0];
          end
        end
        ADDR_DAY_OF_MONTH: begin
          if (wr_page0) begin
            next_cur.date = bus_req.wdata;
          end else if (wr_page1) begin
            next_cur.al_date = bus_req.wdata;
          end
        end
        ADDR_PAGE_CONTROL: begin
          next_cur.irq_en   = bus_req.wdata[PG_IRQ_ENABLE];
          next_cur.run_en   = bus_req.wdata[PG_RUN_ENABLE];
          next_cur.alarm_en = bus_req.wdata[PG_ALARM_EN];
          next_cur.page     = bus_req.wdata[PG_PAGE];
        end
        ADDR_COUNTER_RST: begin
          next_cur.one_hz_off     = bus_req.wdata[CR_ONE_HZ_OFF];
          next_cur.sixteen_hz_off = bus_req.wdata[CR_SIXTEEN_OFF];
          // A new request set in the same cycle as completion survives.
          if (bus_req.wdata[CR_SEC_CLEAR]) begin
            next_cur.clear_req = 1'b1;
          end
          if (bus_req.wdata[CR_FIELD_INIT]) begin
            next_cur.al_min  = INIT_AL_MINUTE;
            next_cur.al_hour = INIT_AL_HOUR;
            next_cur.al_date = INIT_AL_DATE;
            next_cur.al_wday = INIT_AL_WEEKDAY;
          end
        end
        default: begin
        end
      endcase
    end

    // Read data stands for one cycle only and is zero otherwise.
    next_cur.rdata = 8'h00;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        ADDR_SECOND: begin
          next_cur.rdata = rca_page_pick(cur.page, cur.sec, 8'h00);
        end
        ADDR_MINUTE: begin
          next_cur.rdata = rca_page_pick(cur.page, cur.min, cur.al_min);
        end
        ADDR_HOUR: begin
          next_cur.rdata = rca_page_pick(cur.page, cur.hour, cur.al_hour);
        end
        ADDR_WEEKDAY: begin
          next_cur.rdata = rca_page_pick(cur.page, {5'h00, cur.wday},
                                         {5'h00, cur.al_wday});
        end
        ADDR_DAY_OF_MONTH: begin
          next_cur.rdata = rca_page_pick(cur.page, cur.date, cur.al_date);
        end
        ADDR_PAGE_CONTROL: begin
          next_cur.rdata[PG_IRQ_ENABLE] = cur.irq_en;
          next_cur.rdata[PG_RUN_ENABLE] = cur.run_en;
          next_cur.rdata[PG_ALARM_EN]   = cur.alarm_en;
          next_cur.rdata[PG_PAGE]       = cur.page;
        end
        ADDR_COUNTER_RST: begin
          next_cur.rdata[CR_ONE_HZ_OFF]  = cur.one_hz_off;
          next_cur.rdata[CR_SIXTEEN_OFF] = cur.sixteen_hz_off;
          next_cur.rdata[CR_SEC_CLEAR]   = cur.clear_req;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cur <= STATE_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign rdata              = cur.rdata;
  assign events.alarm_n     = ~cur.pulse;
  assign events.clock_irq_n = ~cur.pulse;

endmodule : rca_counter_alarm

/* File: hdl/rca_pkg.sv */
// Package with the register map, field layout and reset values of the clock.
package rca_pkg;

  // Register indices on the plain register port.
  localparam logic [3:0] ADDR_SECOND       = 4'h0;
  localparam logic [3:0] ADDR_MINUTE       = 4'h1;
  localparam logic [3:0] ADDR_HOUR         = 4'h2;
  localparam logic [3:0] ADDR_WEEKDAY      = 4'h3;
  localparam logic [3:0] ADDR_DAY_OF_MONTH = 4'h4;
  localparam logic [3:0] ADDR_PAGE_CONTROL = 4'h7;
  localparam logic [3:0] ADDR_COUNTER_RST  = 4'h8;

  // Field positions in page_control_reg.
  localparam int PG_IRQ_ENABLE = 7;
  localparam int PG_RUN_ENABLE = 3;
  localparam int PG_ALARM_EN   = 2;
  localparam int PG_PAGE       = 0;

  // Field positions in counter_reset_reg.
  localparam int CR_ONE_HZ_OFF  = 7;
  localparam int CR_SIXTEEN_OFF = 6;
  localparam int CR_SEC_CLEAR   = 5;
  localparam int CR_FIELD_INIT  = 4;

  // Reset values.
  localparam logic       RST_ONE_HZ_OFF  = 1'b1;
  localparam logic       RST_SIXTEEN_OFF = 1'b1;
  localparam logic [7:0] RST_DATE        = 8'h01;
  localparam logic [7:0] RST_TIME        = 8'h00;
  localparam logic [2:0] RST_WEEKDAY     = 3'h0;

  // Values loaded by match_fields_init: 00 minute, 00 hour, date 01, Sunday.
  localparam logic [7:0] INIT_AL_MINUTE  = 8'h00;
  localparam logic [7:0] INIT_AL_HOUR    = 8'h00;
  localparam logic [7:0] INIT_AL_DATE    = 8'h01;
  localparam logic [2:0] INIT_AL_WEEKDAY = 3'h0;

  // Calendar limits, BCD coded.
  localparam logic [7:0] LAST_SECOND  = 8'h59;
  localparam logic [7:0] LAST_MINUTE  = 8'h59;
  localparam logic [7:0] LAST_HOUR    = 8'h23;
  localparam logic [7:0] LAST_DATE    = 8'h31;
  localparam logic [2:0] LAST_WEEKDAY = 3'h6;

  // Low-speed clock divider: 32768 edges make one second.
  localparam int          LS_CLOCK_HZ = 32768;
  localparam int          DIV_W       = 15;
  localparam logic [14:0] DIV_LAST    = 15'(LS_CLOCK_HZ - 1);
  localparam int          SIXTEEN_HZ  = 16;
  localparam logic [14:0] DIV16_MASK  = 15'(LS_CLOCK_HZ / SIXTEEN_HZ - 1);

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rca_bus_req_s;

  typedef struct packed {
    logic       alarm_n;
    logic       clock_irq_n;
  } rca_event_s;

endpackage : rca_pkg

/* File: tb/rca_counter_alarm_assertions.sv */
// Port-level assertion checker for the clock core.
`timescale 1ns/10ps
module rca_counter_alarm_chk
  import rca_pkg::*;
#(parameter int LS_PER = 4)
(
  input wire logic         mclk,
  input wire logic         rst_n,
  input wire logic         lsclk,
  input wire rca_bus_req_s bus_req,
  input wire logic [7:0]   rdata,
  input wire rca_event_s   events
);
  logic [7:0]  pg;
  logic [7:0]  cr;
  logic [15:0] gap;
  logic        seen;
  wire         pg_wr = bus_req.wr && bus_req.addr == ADDR_PAGE_CONTROL;
  wire         cr_wr = bus_req.wr && bus_req.addr == ADDR_COUNTER_RST;

  // Shadow of the writable bits; gap counts cycles since the last pulse.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pg   <= 8'h00;
      cr   <= 8'hC0;
      gap  <= 16'h0000;
      seen <= 1'b0;
    end else begin
      pg   <= pg_wr ? (bus_req.wdata & 8'h8D) : pg;
      cr   <= cr_wr ? (bus_req.wdata & 8'hC0) : cr;
      gap  <= $fell(events.alarm_n) ? 16'h0001 : gap + 16'h0001;
      seen <= (pg_wr || cr_wr) ? 1'b0 : (seen || $fell(events.alarm_n));
    end
  end

  a_pins_together:
  assert property (@(posedge mclk) disable iff (!rst_n)
    events.alarm_n == events.clock_irq_n) else $error("pins differ");
  a_pulse_width:
  assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(events.alarm_n) |-> gap == 16'(LS_PER))
    else $error("pulse not one slow period");
  a_irq_gated:
  assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(events.clock_irq_n) |-> $past(pg[PG_IRQ_ENABLE]))
    else $error("pulse while interrupt disabled");
  a_legal_source:
  assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(events.alarm_n) |-> ($past(pg[PG_ALARM_EN]) ?
      $past(cr[7:6]) == 2'b11 : $past(cr[7]) != $past(cr[6])))
    else $error("pulse from an unselected source");
  a_sixteen_gap:
  assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(events.alarm_n) && seen && !$past(pg[PG_ALARM_EN]) &&
    $past(cr[7:6]) == 2'b10 |-> gap == 16'(2048 * LS_PER))
    else $error("sixteen hertz spacing wrong");
  a_page_readback:
  assert property (@(posedge mclk) disable iff (!rst_n)
    $past(bus_req.rd) && $past(bus_req.addr) == ADDR_PAGE_CONTROL |->
    rdata == $past(pg)) else $error("page control readback wrong");
  a_rate_readback:
  assert property (@(posedge mclk) disable iff (!rst_n)
    $past(bus_req.rd) && $past(bus_req.addr) == ADDR_COUNTER_RST |->
    rdata[7:6] == $past(cr[7:6])) else $error("rate bits readback wrong");
  a_rdata_idle:
  assert property (@(posedge mclk) disable iff (!rst_n)
    !$past(bus_req.rd) |-> rdata == 8'h00) else $error("stray read data");
  a_slow_edge_first:
  assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(events.alarm_n) |-> $past(lsclk, 4) && $past(lsclk, 3))
    else $error("pulse not on a slow clock edge");
endmodule : rca_counter_alarm_chk

/* File: tb/rca_counter_alarm_tb.sv */
// Self-checking bench for the clock core.
`timescale 1ns/10ps
module rca_counter_alarm_tb
  import rca_pkg::*;
;
  logic         mclk;
  logic         rst_n;
  logic [1:0]   ph = 2'h0;
  rca_bus_req_s bus_req;
  logic [7:0]   rdata;
  rca_event_s   events;
  int           err_count, checked, taken, t0, t1;
  int           cyc = 0;

  rca_counter_alarm i_rca_counter_alarm (.mclk(mclk), .rst_n(rst_n),
    .lsclk(ph[1]), .bus_req(bus_req), .rdata(rdata), .events(events));
  rca_irq_ctrl_model i_rca_irq_ctrl_model (.mclk(mclk), .rst_n(rst_n),
    .irq_n(events.clock_irq_n), .taken(taken));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // The slow clock is four system cycles so a whole second fits the run.
  always @(posedge mclk) begin
    ph  <= ph + 2'h1;
    cyc <= cyc + 1;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("Counts: %0d compares, %0d mismatches", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // One access; a read compares d against the data of the next cycle.
  task automatic acc(input bit w, input logic [3:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: w ? d : 8'h00, wr: w, rd: !w};
    @(posedge mclk);
    bus_req <= '0;
    #1;
    if (!w) check(32'(rdata), 32'(d));
    @(posedge mclk);
  endtask : acc

  task automatic wait_fall(input int lim, input bit want, output int t);
    t = -1;
    for (int n = 0; n < lim && t < 0; n++) begin
      @(posedge mclk);
      #1;
      if (events.alarm_n === 1'b0) t = cyc;
    end
    check(32'(t >= 0), 32'(want));
    if (t >= 0) check(32'(events.clock_irq_n), 32'h0);
    if ((t >= 0) != want) complete_run();
  endtask : wait_fall

  initial begin
    rst_n     = 1'b0;
    err_count = 0;
    checked   = 0;
    bus_req   = '0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    acc(0, ADDR_PAGE_CONTROL, 8'h00);
    acc(0, ADDR_COUNTER_RST, 8'hC0);
    acc(0, ADDR_DAY_OF_MONTH, RST_DATE);
    acc(0, 4'h5, 8'h00);
    $display("Test reset values ended");
    acc(1, ADDR_PAGE_CONTROL, 8'h09);
    acc(1, ADDR_MINUTE, 8'h33);
    acc(1, ADDR_DAY_OF_MONTH, 8'h22);
    acc(1, ADDR_COUNTER_RST, 8'hD0);
    acc(0, ADDR_MINUTE, INIT_AL_MINUTE);
    acc(0, ADDR_HOUR, INIT_AL_HOUR);
    acc(0, ADDR_DAY_OF_MONTH, INIT_AL_DATE);
    acc(0, ADDR_WEEKDAY, 8'(INIT_AL_WEEKDAY));
    acc(1, ADDR_MINUTE, 8'h01);
    acc(0, ADDR_MINUTE, 8'h01);
    $display("Test alarm fields ended");
    acc(1, ADDR_COUNTER_RST, 8'hA0);
    repeat (12) @(posedge mclk);
    acc(0, ADDR_COUNTER_RST, 8'h80);
    acc(1, ADDR_PAGE_CONTROL, 8'h09);
    acc(1, ADDR_PAGE_CONTROL, 8'h89);
    wait_fall(8400, 1'b1, t0);
    repeat (8) @(posedge mclk);
    wait_fall(8400, 1'b1, t1);
    check(32'(t1 - t0), 32'd8192);
    // The model counts an edge one cycle after the pin shows it.
    repeat (8) @(posedge mclk);
    check(32'(taken), 32'd2);
    $display("Test sixteen hertz ended");
    acc(1, ADDR_PAGE_CONTROL, 8'h09);
    wait_fall(8400, 1'b0, t1);
    acc(1, ADDR_PAGE_CONTROL, 8'h08);
    acc(1, ADDR_SECOND, 8'h59);
    acc(1, ADDR_MINUTE, 8'h00);
    acc(1, ADDR_COUNTER_RST, 8'hC0);
    acc(1, ADDR_PAGE_CONTROL, 8'h0D);
    acc(1, ADDR_PAGE_CONTROL, 8'h8D);
    // The alarm fires on the minute roll that ends the first second.
    wait_fall(120000, 1'b1, t1);
    check(32'(t1 - t0), 32'd122880);
    acc(1, ADDR_PAGE_CONTROL, 8'h8C);
    acc(0, ADDR_SECOND, 8'h00);
    acc(0, ADDR_MINUTE, 8'h01);
    acc(0, ADDR_MINUTE, 8'h01);
    check(32'(taken), 32'd3);
    acc(1, ADDR_PAGE_CONTROL, 8'h0D);
    acc(1, ADDR_MINUTE, 8'h02);
    acc(0, ADDR_MINUTE, 8'h02);
    $display("Test alarm match ended");
    complete_run();
  end
endmodule : rca_counter_alarm_tb

bind rca_counter_alarm rca_counter_alarm_chk #(.LS_PER(4))
  i_rca_counter_alarm_chk (.mclk(mclk), .rst_n(rst_n), .lsclk(lsclk),
  .bus_req(bus_req), .rdata(rdata), .events(events));

/* File: tb/rca_irq_ctrl_model.sv */
// Interrupt controller stand-in that counts falling-edge requests.
`timescale 1ns/10ps
module rca_irq_ctrl_model (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic irq_n,
  output int        taken
);
  logic last_n;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      last_n <= 1'b1;
      taken  <= 0;
    end else begin
      last_n <= irq_n;
      // A held low level must not count twice, so only the edge counts.
      taken  <= (last_n && !irq_n) ? taken + 1 : taken;
    end
  end
endmodule : rca_irq_ctrl_model
